//--- rpac_far_end.sv
`timescale 1ns/1ns
module rpac_far_end (
  input  wire logic   ref_clk,
  output logic        ptr_strobe,
  output logic [15:0] ptr_word,
  output logic        ptr_valid,
  output logic        ptr_ais,
  output logic        conc_strobe,
  output logic [3:0]  conc_pair,
  output logic [15:0] conc_word,
  output logic [1:0]  au_struct,
  output logic        msa_ais_gen
);
  logic [15:0] pw, cw;
  // unqualified bytes never repeat the last sample
  assign ptr_word  = ptr_strobe ? pw : ~pw;
  assign conc_word = conc_strobe ? cw : ~cw;
  initial begin
    pw          = 16'h0000;
    cw          = 16'h0000;
    ptr_strobe  = 1'h0;
    ptr_valid   = 1'h1;
    ptr_ais     = 1'h0;
    conc_strobe = 1'h0;
    conc_pair   = 4'h0;
    au_struct   = 2'h0;
    msa_ais_gen = 1'h0;
  end
  task automatic send_ptr(input logic [15:0] w, input int gap);
    pw         <= w;
    ptr_strobe <= 1'h1;
    @(posedge ref_clk);
    ptr_strobe <= 1'h0;
    repeat (gap + 1) @(posedge ref_clk);
  endtask
  task automatic send_conc(input logic [3:0] p, input logic [15:0] w);
    cw          <= w;
    conc_pair   <= p;
    conc_strobe <= 1'h1;
    @(posedge ref_clk);
    conc_strobe <= 1'h0;
    @(posedge ref_clk);
  endtask
endmodule

//--- rpac_just_detect.sv
`timescale 1ns/1ns
// pointer justification decision from received 10-bit pointer
module rpac_just_detect (
  input  wire logic [9:0] ptr_value,
  input  wire logic [9:0] ptr_prev,
  input  wire logic       rule_sonet,
  output logic            inc,
  output logic            dec
);
  // pointer bits alternate I,D,I,D... from msb
  logic [9:0] diff;
  logic [4:0] ibits;
  logic [4:0] dbits;
  logic [2:0] icnt;
  logic [2:0] dcnt;
  logic [3:0] icnt8;
  logic [3:0] dcnt8;
  logic [9:0] ipat;
  logic [9:0] dpat;

  always_comb begin
    diff = ptr_value ^ ptr_prev;
    for (int k = 0; k < 5; k++) begin
      ibits[k] = diff[2*k+1];
      dbits[k] = diff[2*k];
    end
    icnt = 3'h0;
    dcnt = 3'h0;
    for (int k = 0; k < 5; k++) begin
      icnt = icnt + {2'b00, ibits[k]};
      dcnt = dcnt + {2'b00, dbits[k]};
    end
    // sonet: 8 of 10 bits match the all-I-inverted (inc) or all-D-inverted (dec) pattern
    ipat = ~(diff ^ 10'b10_1010_1010);
    dpat = ~(diff ^ 10'b01_0101_0101);
    icnt8 = 4'h0;
    dcnt8 = 4'h0;
    for (int k = 0; k < 10; k++) begin
      icnt8 = icnt8 + {3'b000, ipat[k]};
      dcnt8 = dcnt8 + {3'b000, dpat[k]};
    end
    if (rule_sonet) begin
      inc = (icnt8 >= 4'h8);
      dec = (dcnt8 >= 4'h8);
    end else begin
      inc = (icnt >= 3'h3) && (dcnt < 3'h3);
      dec = (dcnt >= 3'h3) && (icnt < 3'h3);
    end
  end
endmodule

//--- rpac_pkg.sv
package rpac_pkg;
  // register word indices, byte address is index times four
  localparam logic [7:0] CFG_IDX       = 8'ha0;
  localparam logic [7:0] NCNT_IDX      = 8'ha1;
  localparam logic [7:0] IRQ_STAT_IDX  = 8'ha2;
  localparam logic [7:0] IRQ_MASK_IDX  = 8'ha3;
  localparam logic [7:0] STATUS_IDX    = 8'ha4;
  localparam int         ADDR_W        = 10;
  localparam logic [ADDR_W-1:0] CFG_ADDR      = {CFG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] NCNT_ADDR     = {NCNT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_ADDR   = {STATUS_IDX, 2'b00};

  // configuration field positions
  localparam int CFG_AISC_EN   = 9;
  localparam int CFG_LOPC_SD   = 8;
  localparam int CFG_LOPC_AIS  = 7;
  localparam int CFG_PAIR_SEL  = 6;
  localparam int CFG_JUST_RULE = 5;
  localparam int CFG_SS_HI     = 4;
  localparam int CFG_SS_LO     = 3;
  localparam int CFG_AUTO_AIS  = 2;
  localparam int CFG_AIS_FRC   = 1;
  localparam int CFG_SS_EN     = 0;
  localparam int CFG_W         = 10;
  localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;

  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] CNT_RESET = 11'h000;

  // interrupt status bits
  localparam int IRQ_W         = 2;
  localparam int IRQ_NEG_OVF   = 0;
  localparam int IRQ_LOPC_CHG  = 1;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // structure sizes (per STM-1 equivalent pairs)
  localparam int NPAIR = 16;

  typedef enum logic [1:0] {
    RPAC_AU4   = 2'b00,
    RPAC_AU4C4 = 2'b01,
    RPAC_AU4C16 = 2'b11
  } rpac_struct_t;
endpackage

//--- rpac_properties.sv
`timescale 1ns/1ns
module rpac_properties (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic [9:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        msa_ais_gen,
  input wire logic        path_remote_defect_indication,
  input wire logic        adaptation_ais_insert
);
  logic [9:0] aw_a, next_aw_a, cfg_s, next_cfg_s, w_d, next_w_d;
  logic       aw_got, next_aw_got, w_got, next_w_got, quiet, mapped, bdone;
  assign bdone  = s_axi_bvalid && s_axi_bready;
  assign quiet  = !aw_got && !w_got && !s_axi_bvalid;
  assign mapped = aw_a[9:2] inside {[rpac_pkg::CFG_IDX:rpac_pkg::STATUS_IDX]};
  // shadow of the configuration, taken once a write has completed
  always_comb begin
    next_aw_a   = aw_a;
    next_w_d    = w_d;
    next_cfg_s  = cfg_s;
    next_aw_got = aw_got && !bdone;
    next_w_got  = w_got && !bdone;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_a   = s_axi_awaddr;
      next_aw_got = 1'h1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_d   = s_axi_wdata[9:0];
      next_w_got = 1'h1;
    end
    if (bdone && aw_a == rpac_pkg::CFG_ADDR) begin
      next_cfg_s = w_d;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_a   <= '0;
      w_d    <= '0;
      cfg_s  <= '0;
      aw_got <= 1'h0;
      w_got  <= 1'h0;
    end else begin
      aw_a   <= next_aw_a;
      w_d    <= next_w_d;
      cfg_s  <= next_cfg_s;
      aw_got <= next_aw_got;
      w_got  <= next_w_got;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_settled;
    quiet ##1 quiet;
  endsequence
  sequence s_read_req;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_arready_inv:
    assert property (s_axi_arready == !s_axi_rvalid)
      else $error("arready not inverse of rvalid");
  a_read_answer:
    assert property (s_read_req |=> s_axi_rvalid)
      else $error("read not answered next cycle");
  a_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped early");
  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
  a_write_answer:
    assert property (aw_got && w_got && !s_axi_bvalid |-> ##[1:3] s_axi_bvalid)
      else $error("write not answered");
  a_unmapped_err:
    assert property (s_axi_bvalid && aw_got && !mapped
                     |-> s_axi_bresp == rpac_pkg::RESP_SLVERR)
      else $error("unmapped write not refused");
  a_force_ais:
    assert property (s_settled ##0 cfg_s[1] |-> adaptation_ais_insert)
      else $error("forced ais missing");
  a_auto_ais:
    assert property (s_settled ##0 (cfg_s[2] && $past(msa_ais_gen))
                     |-> adaptation_ais_insert)
      else $error("automatic ais not passed");
  a_ais_cause:
    assert property (s_settled ##0 $rose(adaptation_ais_insert)
                     |-> cfg_s[1] || cfg_s[7] || cfg_s[2] && $past(msa_ais_gen))
      else $error("ais inserted without cause");
  a_rdi_cause:
    assert property (s_settled ##0 $rose(path_remote_defect_indication)
                     |-> cfg_s[8])
      else $error("rdi forced while disabled");
endmodule
bind rpac_top rpac_properties i_rpac_properties (.*);

//--- rpac_tb_top.sv
`timescale 1ns/1ns
module rpac_tb_top;
  logic        ref_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic        ptr_strobe, ptr_valid, ptr_ais, conc_strobe, msa_ais_gen;
  logic        pointer_ais_defect, concat_pointer_loss_status;
  logic        loss_of_pointer, path_remote_defect_indication;
  logic        adaptation_ais_insert;
  logic [9:0]  s_axi_awaddr, s_axi_araddr, cur;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v, v, rule_v;
  logic [15:0] ptr_word, conc_word;
  logic [3:0]  s_axi_wstrb, conc_pair;
  logic [1:0]  s_axi_bresp, s_axi_rresp, au_struct, rsp;
  int          error_cnt, n_checks, seed, ndec, gap;
  rpac_top     i_rpac_top (.*);
  rpac_far_end i_rpac_far_end (.*);
  always #50 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 99);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    chk("write answer", 1, n < 99);
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [9:0] a);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 99);
    rd_v = s_axi_rdata;
    rsp  = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk("read answer", 1, n < 99);
    @(posedge ref_clk);
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic ptr(input logic [1:0] ss, input logic [9:0] p);
    i_rpac_far_end.send_ptr({4'h6, ss, p}, 1);
    settle;
  endtask
  task automatic conc8(input logic [3:0] p, input logic [15:0] w);
    repeat (8) i_rpac_far_end.send_conc(p, w);
    settle;
  endtask
  // every pointer is cur with I or D bits inverted, so each one counts
  task automatic just_run(input int n_ev);
    repeat (n_ev) begin
      gap = $random(seed) & 3;
      if ($random(seed) & 1) begin
        v = 32'h0000_0155;
        ndec++;
      end else begin
        v = 32'h0000_02aa;
      end
      i_rpac_far_end.send_ptr({4'h6, 2'h2, cur ^ v[9:0]}, gap);
    end
    settle;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    seed          = 19662;
    ref_clk       = 1'h0;
    resetn        = 1'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid  = 1'h0;
    s_axi_bready  = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready  = 1'h0;
    s_axi_awaddr  = 10'h000;
    s_axi_araddr  = 10'h000;
    s_axi_wdata   = 32'h0000_0000;
    s_axi_wstrb   = 4'hf;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rd(rpac_pkg::CFG_ADDR);
    chk("cfg reset", 0, rd_v);
    rd(rpac_pkg::NCNT_ADDR);
    chk("count reset", 0, rd_v);
    rd(10'h004);
    chk("unmapped read", rpac_pkg::RESP_SLVERR, rsp);
    chk("unmapped data", 0, rd_v);
    wr(10'h3fc, 32'h0000_0001);
    chk("unmapped write", rpac_pkg::RESP_SLVERR, rsp);
    v = $random(seed);
    wr(rpac_pkg::CFG_ADDR, v);
    rd(rpac_pkg::CFG_ADDR);
    chk("cfg readback", {22'h0, v[9:0]}, rd_v);
    wr(rpac_pkg::CFG_ADDR, 32'h0000_0002);
    settle;
    chk("forced ais", 1, adaptation_ais_insert);
    i_rpac_far_end.msa_ais_gen <= 1'h1;
    wr(rpac_pkg::CFG_ADDR, 32'h0000_0004);
    settle;
    chk("auto ais on", 1, adaptation_ais_insert);
    wr(rpac_pkg::CFG_ADDR, 32'h0000_0000);
    settle;
    chk("auto ais off", 0, adaptation_ais_insert);
    i_rpac_far_end.msa_ais_gen <= 1'h0;
    wr(rpac_pkg::CFG_ADDR, 32'h0000_0011);
    ptr(2'h1, 10'h064);
    chk("size mismatch", 1, loss_of_pointer);
    ptr(2'h2, 10'h064);
    chk("size match", 0, loss_of_pointer);
    wr(rpac_pkg::CFG_ADDR, 32'h0000_0000);
    ptr(2'h1, 10'h064);
    chk("size check off", 0, loss_of_pointer);
    wr(rpac_pkg::CFG_ADDR, 32'h0000_01c0);
    conc8(4'h3, 16'h0000);
    chk("single au pairs", 0, concat_pointer_loss_status);
    i_rpac_far_end.au_struct <= 2'h1;
    wr(rpac_pkg::CFG_ADDR, 32'h0000_0180);
    conc8(4'h1, 16'h0000);
    chk("concat loss", 1, concat_pointer_loss_status);
    chk("rdi on loss", 1, path_remote_defect_indication);
    chk("ais on loss", 1, adaptation_ais_insert);
    wr(rpac_pkg::CFG_ADDR, 32'h0000_0000);
    settle;
    chk("rdi disabled", 0, path_remote_defect_indication);
    chk("ais disabled", 0, adaptation_ais_insert);
    wr(rpac_pkg::CFG_ADDR, 32'h0000_0040);
    conc8(4'h3, 16'h93ff);
    chk("pair 4 checked", 0, concat_pointer_loss_status);
    conc8(4'h4, 16'h0000);
    chk("pair 5 skipped", 0, concat_pointer_loss_status);
    i_rpac_far_end.au_struct <= 2'h3;
    i_rpac_far_end.ptr_ais   <= 1'h1;
    conc8(4'h4, 16'h0000);
    chk("pair 5 in 16c", 1, concat_pointer_loss_status);
    wr(rpac_pkg::CFG_ADDR, 32'h0000_0240);
    settle;
    chk("ais needs aisc", 0, pointer_ais_defect);
    conc8(4'h4, 16'hffff);
    chk("ais with aisc", 1, pointer_ais_defect);
    rd(rpac_pkg::STATUS_ADDR);
    chk("status", 32'h0000_0005, rd_v);
    i_rpac_far_end.ptr_ais <= 1'h0;
    rule_v = $random(seed) & 32'h0000_0020;
    wr(rpac_pkg::CFG_ADDR, rule_v);
    // small offset from the last pointer, never a justification
    cur = 10'h064 ^ 10'($random(seed) & 3);
    ptr(2'h2, cur);
    wr(rpac_pkg::NCNT_ADDR, 32'h0000_0000);
    wr(rpac_pkg::IRQ_STAT_ADDR, 32'h0000_0003);
    wr(rpac_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
    ndec = 0;
    just_run(4400);
    chk("overflow irq", ndec >= 2048, irq);
    rd(rpac_pkg::IRQ_STAT_ADDR);
    chk("overflow flag", ndec >= 2048, rd_v[0]);
    wr(rpac_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
    settle;
    chk("irq cleared", 0, irq);
    wr(rpac_pkg::NCNT_ADDR, 32'h0000_0000);
    rd(rpac_pkg::NCNT_ADDR);
    chk("negative count", ndec % 2048, rd_v);
    wr(rpac_pkg::NCNT_ADDR, 32'h0000_0000);
    rd(rpac_pkg::NCNT_ADDR);
    chk("count after clear", 0, rd_v);
    wr(rpac_pkg::CFG_ADDR, rule_v ^ 32'h0000_0020);
    ndec = 0;
    just_run(40);
    wr(rpac_pkg::NCNT_ADDR, 32'h0000_0000);
    rd(rpac_pkg::NCNT_ADDR);
    chk("other rule count", ndec, rd_v);
    resetn <= 1'h0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rd(rpac_pkg::CFG_ADDR);
    chk("cfg after reset", 0, rd_v);
    rd(rpac_pkg::NCNT_ADDR);
    chk("count after reset", 0, rd_v);
    report_and_stop;
  end
endmodule

//--- rpac_top.sv
`timescale 1ns/1ns
// Behaviour
// - With the AISC check on, pointer AIS is flagged only when both pointer and concatenation indicators show AIS.
// - With its enable set, concatenation loss forces a server defect into path RDI.
// - With its enable set, concatenation loss inserts AIS downstream.
// - Pair select zero checks every non-pointer H1/H2 pair for indicator or all-ones.
// - Pair select one checks none for AU-4, pairs 2-4 for AU-4-4c, pairs 2-16 for AU-4-16c.
// - SONET rule counts a justification when 8 of 10 bits show only I or only D inverted.
// - SDH rule uses a 3-of-5 majority on I or D bits with fewer than 3 of the other set inverted.
// - With size check on, size bits unequal to the expected value raise loss of pointer.
// - Automatic AIS passes to path termination only while auto AIS is enabled.
// - The AIS force bit sends AIS to path termination unconditionally.
// - Each negative justification event increments a dedicated counter, except in a cycle where a counter register write clears it.
// - The counter is 11 bits in the low bits of its register, upper bits zero.
// - A write to the counter register copies the count into a buffer and clears it; reads return the buffer.
// - Each counter rollover sets a sticky overflow flag, cleared by software.
module rpac_top (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // AXI4-Lite slave
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // receive pointer inputs, one sample per strobe
  input  wire logic        ptr_strobe,
  input  wire logic [15:0] ptr_word,
  input  wire logic        ptr_valid,
  input  wire logic        ptr_ais,
  input  wire logic        conc_strobe,
  input  wire logic [3:0]  conc_pair,
  input  wire logic [15:0] conc_word,
  input  wire logic [1:0]  au_struct,
  input  wire logic        msa_ais_gen,
  // outputs
  output logic             pointer_ais_defect,
  output logic             concat_pointer_loss_status,
  output logic             loss_of_pointer,
  output logic             path_remote_defect_indication,
  output logic             adaptation_ais_insert,
  output logic             irq
);
  logic [rpac_pkg::CFG_W-1:0] cfg, next_cfg;
  logic [rpac_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [rpac_pkg::CNT_W-1:0] cnt_buf, next_cnt_buf;
  logic [rpac_pkg::IRQ_W-1:0] istat, next_istat;
  logic [rpac_pkg::IRQ_W-1:0] imask, next_imask;
  logic [9:0]  ptr_prev, next_ptr_prev;
  logic        lopc, next_lopc;
  logic        aisc, next_aisc;
  logic        pais, next_pais;
  logic        lop, next_lop;
  logic        rdi, next_rdi;
  logic        ais_ins, next_ais_ins;
  logic        irq_q, next_irq;
  logic        awr, next_awr, wr, next_wr, bv, next_bv;
  logic        rv, next_rv, arr, next_arr;
  logic [1:0]  br, next_br, rr, next_rr;
  logic [31:0] rd, next_rd;
  logic [9:0]  aw_q, next_aw_q;
  logic [31:0] wd_q, next_wd_q;
  logic        aw_have, next_aw_have, w_have, next_w_have;
  logic        inc, dec;
  logic        pair_checked;
  logic        conc_ok;
  logic        do_wr;
  logic [9:0]  wa;
  logic [31:0] wdat;

  rpac_just_detect u_just (
    .ptr_value  (ptr_word[9:0]),
    .ptr_prev   (ptr_prev),
    .rule_sonet (cfg[rpac_pkg::CFG_JUST_RULE]),
    .inc        (inc),
    .dec        (dec)
  );

  // which indicator pairs take part in concatenation checking
  always_comb begin
    pair_checked = 1'b0;
    if (conc_pair != 4'h0) begin
      if (!cfg[rpac_pkg::CFG_PAIR_SEL]) begin
        pair_checked = 1'b1;
      end else begin
        unique case (au_struct)
          rpac_pkg::RPAC_AU4:    pair_checked = 1'b0;
          rpac_pkg::RPAC_AU4C4:  pair_checked = (conc_pair <= 4'h3);
          rpac_pkg::RPAC_AU4C16: pair_checked = 1'b1;
          default:               pair_checked = 1'b0;
        endcase
      end
    end
    // indicator 1001 ss 1111111111, ss checked only if enabled
    conc_ok = (conc_word == 16'hffff) ||
              ((conc_word[15:12] == 4'b1001) &&
               (conc_word[9:0] == 10'h3ff) &&
               (!cfg[rpac_pkg::CFG_SS_EN] ||
                conc_word[11:10] ==
                cfg[rpac_pkg::CFG_SS_HI:rpac_pkg::CFG_SS_LO]));
  end

  // defects and justification counting
  always_comb begin
    next_ptr_prev = ptr_prev;
    next_lopc     = lopc;
    next_aisc     = aisc;
    next_lop      = lop;
    next_cnt      = cnt;
    next_istat    = istat;
    if (conc_strobe && pair_checked) begin
      next_lopc = !conc_ok;
      next_aisc = (conc_word == 16'hffff);
    end
    if (ptr_strobe) begin
      next_lop = !ptr_valid ||
                 (cfg[rpac_pkg::CFG_SS_EN] &&
                  ptr_word[11:10] !=
                  cfg[rpac_pkg::CFG_SS_HI:rpac_pkg::CFG_SS_LO]);
      if (ptr_valid && !inc && !dec) begin
        next_ptr_prev = ptr_word[9:0];
      end
      if (ptr_valid && dec) begin
        next_cnt = cnt + 11'h001;
        if (cnt == 11'h7ff) begin
          next_istat[rpac_pkg::IRQ_NEG_OVF] = 1'b1;
        end
      end
    end
    if (next_lopc != lopc) begin
      next_istat[rpac_pkg::IRQ_LOPC_CHG] = 1'b1;
    end
    next_pais = ptr_ais &&
                (!cfg[rpac_pkg::CFG_AISC_EN] || next_aisc);
    next_rdi  = cfg[rpac_pkg::CFG_LOPC_SD] && next_lopc;
    next_ais_ins = cfg[rpac_pkg::CFG_AIS_FRC] ||
                   (cfg[rpac_pkg::CFG_AUTO_AIS] && msa_ais_gen) ||
                   (cfg[rpac_pkg::CFG_LOPC_AIS] && next_lopc);
    // register writes; hardware set beats software clear
    next_cfg = cfg;
    next_imask = imask;
    next_cnt_buf = cnt_buf;
    if (do_wr) begin
      if (wa == rpac_pkg::CFG_ADDR) begin
        next_cfg = wdat[rpac_pkg::CFG_W-1:0];
      end
      if (wa == rpac_pkg::NCNT_ADDR) begin
        next_cnt_buf = cnt;
        next_cnt = rpac_pkg::CNT_RESET;
      end
      if (wa == rpac_pkg::IRQ_MASK_ADDR) begin
        next_imask = wdat[rpac_pkg::IRQ_W-1:0];
      end
      if (wa == rpac_pkg::IRQ_STAT_ADDR) begin
        next_istat = next_istat & ~(wdat[rpac_pkg::IRQ_W-1:0] & ~(next_istat
                     ^ istat));
      end
    end
    next_irq = |(next_istat & next_imask);
  end

  // AXI4-Lite write: address and data taken in either order
  always_comb begin
    next_aw_have = aw_have;
    next_w_have  = w_have;
    next_aw_q    = aw_q;
    next_wd_q    = wd_q;
    next_bv      = bv;
    next_br      = br;
    if (s_axi_awvalid && awr) begin
      next_aw_have = 1'b1;
      next_aw_q    = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr) begin
      next_w_have = 1'b1;
      next_wd_q   = s_axi_wdata;
    end
    if (bv && s_axi_bready) begin
      next_bv = 1'b0;
    end
    do_wr = aw_have && w_have && !bv;
    wa    = aw_q;
    wdat  = wd_q;
    if (do_wr) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bv      = 1'b1;
      next_br      = (wa == rpac_pkg::CFG_ADDR ||
                      wa == rpac_pkg::NCNT_ADDR ||
                      wa == rpac_pkg::IRQ_STAT_ADDR ||
                      wa == rpac_pkg::IRQ_MASK_ADDR ||
                      wa == rpac_pkg::STATUS_ADDR) ?
                     rpac_pkg::RESP_OKAY : rpac_pkg::RESP_SLVERR;
    end
    next_awr = !next_aw_have && !next_bv;
    next_wr  = !next_w_have && !next_bv;
  end

  // AXI4-Lite read
  always_comb begin
    next_rv = rv;
    next_rd = rd;
    next_rr = rr;
    if (rv && s_axi_rready) begin
      next_rv = 1'b0;
    end
    if (s_axi_arvalid && arr) begin
      next_rv = 1'b1;
      next_rr = rpac_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        rpac_pkg::CFG_ADDR:      next_rd = {22'h00_0000, cfg};
        rpac_pkg::NCNT_ADDR:     next_rd = {21'h00_0000, cnt_buf};
        rpac_pkg::IRQ_STAT_ADDR: next_rd = {30'h0000_0000, istat};
        rpac_pkg::IRQ_MASK_ADDR: next_rd = {30'h0000_0000, imask};
        rpac_pkg::STATUS_ADDR:
          next_rd = {28'h000_0000, lopc, aisc, lop, pais};
        default: begin
          next_rd = 32'h0000_0000;
          next_rr = rpac_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_arr = !next_rv;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg      <= rpac_pkg::CFG_RESET;
      cnt      <= rpac_pkg::CNT_RESET;
      cnt_buf  <= rpac_pkg::CNT_RESET;
      istat    <= 2'h0;
      imask    <= 2'h0;
      ptr_prev <= 10'h000;
      lopc     <= 1'b0;
      aisc     <= 1'b0;
      pais     <= 1'b0;
      lop      <= 1'b0;
      rdi      <= 1'b0;
      ais_ins  <= 1'b0;
      irq_q    <= 1'b0;
      awr      <= 1'b0;
      wr       <= 1'b0;
      bv       <= 1'b0;
      br       <= 2'h0;
      rv       <= 1'b0;
      arr      <= 1'b1;
      rr       <= 2'h0;
      rd       <= 32'h0000_0000;
      aw_q     <= 10'h000;
      wd_q     <= 32'h0000_0000;
      aw_have  <= 1'b0;
      w_have   <= 1'b0;
    end else begin
      cfg      <= next_cfg;
      cnt      <= next_cnt;
      cnt_buf  <= next_cnt_buf;
      istat    <= next_istat;
      imask    <= next_imask;
      ptr_prev <= next_ptr_prev;
      lopc     <= next_lopc;
      aisc     <= next_aisc;
      pais     <= next_pais;
      lop      <= next_lop;
      rdi      <= next_rdi;
      ais_ins  <= next_ais_ins;
      irq_q    <= next_irq;
      awr      <= next_awr;
      wr       <= next_wr;
      bv       <= next_bv;
      br       <= next_br;
      rv       <= next_rv;
      arr      <= next_arr;
      rr       <= next_rr;
      rd       <= next_rd;
      aw_q     <= next_aw_q;
      wd_q     <= next_wd_q;
      aw_have  <= next_aw_have;
      w_have   <= next_w_have;
    end
  end

  assign s_axi_awready = awr;
  assign s_axi_wready  = wr;
  assign s_axi_bvalid  = bv;
  assign s_axi_bresp   = br;
  assign s_axi_arready = arr;
  assign s_axi_rvalid  = rv;
  assign s_axi_rresp   = rr;
  assign s_axi_rdata   = rd;
  assign pointer_ais_defect            = pais;
  assign concat_pointer_loss_status    = lopc;
  assign loss_of_pointer               = lop;
  assign path_remote_defect_indication = rdi;
  assign adaptation_ais_insert         = ais_ins;
  assign irq                           = irq_q;
endmodule
